/* File: rtl/apm_host_channels.sv */
// Two power-management mailbox channels between host and embedded core.
// Assumes APB from the core and host strobes already decoded to chip selects.
`timescale 1ns/1ps
`default_nettype none
module apm_host_channels
  import apm_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic [17:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire apm_host_req_t         host_req,
  output logic      [7:0]            host_rdata,
  output logic                       host_rvalid,
  output logic      [APM_NUM_CH-1:0] host_irq,
  output logic      [APM_NUM_CH-1:0] smi_n,
  output logic      [APM_NUM_CH-1:0] ec_event_interrupt_n,
  output logic      [APM_NUM_CH-1:0] core_irq_in_full,
  output logic      [APM_NUM_CH-1:0] core_irq_out_empty
);

  // Bus phase decode
  wire        apb_setup = psel & ~penable;
  wire        wr_acc    = psel & penable & pwrite;
  wire        rd_acc    = psel & penable & ~pwrite;
  wire        word_ok   = (paddr[1:0] == 2'b00);
  wire [15:0] reg_idx   = paddr[17:2];

  wire hit_hic = word_ok & (reg_idx == APM_HOST_IF_CTRL_IDX);
  wire hit_hiq = word_ok & (reg_idx == APM_HOST_IRQ_CTRL_IDX);

  // Shared registers
  logic [7:0] host_if_control_reg;
  logic [7:0] host_irq_control_reg;

  wire compat_in_full_core_irq_en  = host_if_control_reg[APM_HIC_IN_FULL_BIT];
  wire compat_out_empty_core_irq_en = host_if_control_reg[APM_HIC_OUT_EMPTY_BIT];
  wire hw_host_irq_enable          = host_if_control_reg[APM_HIC_HW_IRQ_BIT];
  wire irq_invert_select           = host_irq_control_reg[APM_HIQ_INVERT_BIT];
  wire firmware_irq_level_bit      = host_irq_control_reg[APM_HIQ_FW_IRQ_BIT];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      host_if_control_reg  <= APM_HIC_RESET;
      host_irq_control_reg <= APM_HIQ_RESET;
    end else begin
      if (wr_acc & hit_hic) begin
        host_if_control_reg <= pwdata[7:0] & APM_HIC_MASK;
      end
      if (wr_acc & hit_hiq) begin
        host_irq_control_reg <= pwdata[7:0] & APM_HIQ_MASK;
      end
    end
  end

  // Channel results gathered for the read muxes
  logic [APM_NUM_CH-1:0]      ch_hit;
  logic [APM_NUM_CH-1:0][7:0] ch_rdata;
  logic [APM_NUM_CH-1:0][7:0] ch_dout;
  logic [APM_NUM_CH-1:0][7:0] ch_status;
  logic [APM_NUM_CH-1:0]      host_irq_reg;
  logic [APM_NUM_CH-1:0]      smi_n_reg;
  logic [APM_NUM_CH-1:0]      sci_n_reg;

  genvar gi;
  generate
    for (gi = 0; gi < APM_NUM_CH; gi++) begin : g_ch
      logic [7:0] st_core_reg;
      logic       output_full_flag;
      logic       input_full_flag;
      logic       cmd_flag_reg;
      logic [7:0] host_input_buffer;
      logic [7:0] host_output_buffer;
      logic [7:0] chan_control_reg;
      logic [7:0] chan_irq_control_reg;
      logic [7:0] chan_irq_enable_reg;
      logic       out_smi_pending;
      logic       out_sci_pending;
      logic       in_sci_pending;
      logic       out_full_next;
      logic       in_full_next;
      logic       smi_pulse_n;
      logic       sci_pulse_n;

      // Core register decode
      wire hit_st  = word_ok & (reg_idx == APM_ST_IDX[gi]);
      wire hit_do  = word_ok & (reg_idx == APM_DO_IDX[gi]);
      wire hit_di  = word_ok & (reg_idx == APM_DI_IDX[gi]);
      wire hit_doc = word_ok & (reg_idx == APM_DOC_IDX[gi]);
      wire hit_dom = word_ok & (reg_idx == APM_DOM_IDX[gi]);
      wire hit_dic = word_ok & (reg_idx == APM_DIC_IDX[gi]);
      wire hit_ctl = word_ok & (reg_idx == APM_CTL_IDX[gi]);
      wire hit_ic  = word_ok & (reg_idx == APM_IC_IDX[gi]);
      wire hit_ie  = word_ok & (reg_idx == APM_IE_IDX[gi]);

      wire wr_do   = wr_acc & hit_do;
      wire wr_dom  = wr_acc & hit_dom;
      wire wr_doc  = wr_acc & hit_doc;
      wire rd_dic  = rd_acc & hit_dic;
      wire core_do_wr = wr_do | wr_dom | wr_doc;
      wire core_di_rd = (rd_acc & hit_di) | rd_dic;

      // Host side strobes for this channel
      wire host_wr_data = host_req.wr & host_req.sel_data[gi];
      wire host_wr_cmd  = host_req.wr & host_req.sel_cmd[gi];
      wire host_wr_ch   = host_wr_data | host_wr_cmd;
      wire host_rd_data = host_req.rd & host_req.sel_data[gi];

      // Channel two ignores the mode bit and always runs enhanced
      wire compat_mode = (gi == 0) & ~chan_control_reg[APM_CTL_MODE_BIT];

      // Setting wins over clearing on both buffer flags
      assign out_full_next = core_do_wr | (output_full_flag & ~host_rd_data);
      assign in_full_next  = host_wr_ch | (input_full_flag & ~core_di_rd);
      wire out_full_clear  = output_full_flag & ~out_full_next;

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          output_full_flag <= 1'b0;
          input_full_flag  <= 1'b0;
          cmd_flag_reg     <= 1'b0;
        end else begin
          output_full_flag <= out_full_next;
          input_full_flag  <= in_full_next;
          if (host_wr_ch) begin
            cmd_flag_reg <= host_wr_cmd;
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          host_input_buffer  <= 8'h00;
          host_output_buffer <= 8'h00;
        end else begin
          if (host_wr_ch) begin
            host_input_buffer <= host_req.wdata;
          end
          if (core_do_wr) begin
            host_output_buffer <= pwdata[7:0];
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          out_smi_pending <= 1'b0;
          out_sci_pending <= 1'b0;
          in_sci_pending  <= 1'b0;
        end else begin
          out_smi_pending <= wr_dom | (out_smi_pending & ~out_full_clear);
          out_sci_pending <= wr_doc | (out_sci_pending & ~out_full_clear);
          in_sci_pending  <= rd_dic | (in_sci_pending & ~host_wr_ch);
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          st_core_reg          <= APM_ST_RESET;
          chan_control_reg     <= APM_CTL_RESET;
          chan_irq_control_reg <= APM_IC_RESET;
          chan_irq_enable_reg  <= APM_IE_RESET;
        end else begin
          if (wr_acc & hit_st) begin
            st_core_reg <= pwdata[7:0] & APM_ST_CORE_MASK;
          end
          if (wr_acc & hit_ctl) begin
            chan_control_reg <= pwdata[7:0] & APM_CTL_MASK;
          end
          if (wr_acc & hit_ic) begin
            chan_irq_control_reg <= pwdata[7:0] & APM_IC_MASK;
          end
          if (wr_acc & hit_ie) begin
            chan_irq_enable_reg <= pwdata[7:0] & APM_IE_MASK;
          end
        end
      end

      // Status byte seen identically by host and core
      wire [7:0] status_byte = st_core_reg
                             | ({7'h00, input_full_flag} << APM_ST_IN_FULL_BIT)
                             | ({7'h00, cmd_flag_reg} << APM_ST_CMD_BIT)
                             | ({7'h00, output_full_flag} << APM_ST_OUT_FULL_BIT);

      wire [7:0] ic_read = chan_irq_control_reg
                         | {out_smi_pending, out_sci_pending, in_sci_pending, 5'h00};

      assign ch_hit[gi] = hit_st | hit_do | hit_di | hit_doc | hit_dom
                        | hit_dic | hit_ctl | hit_ic | hit_ie;
      assign ch_rdata[gi] = hit_st ? status_byte :
                            (hit_di | hit_dic) ? host_input_buffer :
                            hit_ctl ? chan_control_reg :
                            hit_ic ? ic_read :
                            hit_ie ? chan_irq_enable_reg : 8'h00;
      assign ch_dout[gi]   = host_output_buffer;
      assign ch_status[gi] = status_byte;

      // Core interrupt enables chosen by mode
      wire in_full_en = compat_mode ? compat_in_full_core_irq_en
                                    : chan_control_reg[APM_CTL_IN_FULL_BIT];
      wire out_empty_en = compat_mode ? compat_out_empty_core_irq_en
                                      : chan_control_reg[APM_CTL_OUT_EMPTY_BIT];
      assign core_irq_in_full[gi]   = in_full_en & input_full_flag;
      assign core_irq_out_empty[gi] = out_empty_en & ~output_full_flag;

      // Host IRQ: hardware follows output-full, firmware bit otherwise
      wire irq_route_enable = chan_irq_enable_reg[APM_IE_IRQ_BIT];
      wire irq_hw_src = ~compat_mode | hw_host_irq_enable;
      wire irq_hw_lvl = (irq_route_enable & output_full_flag) ^ irq_invert_select;
      wire irq_lvl = irq_hw_src ? irq_hw_lvl : firmware_irq_level_bit;

      // Active-low pulses for SMI and event outputs
      apm_pulse_gen u_smi_pulse (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .trigger (wr_dom),
        .width   (chan_irq_control_reg[APM_IC_SMIW_LSB +: APM_PW_BITS]),
        .pulse_n (smi_pulse_n)
      );

      apm_pulse_gen u_sci_pulse (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .trigger (wr_doc | rd_dic),
        .width   (chan_control_reg[APM_CTL_SCIW_LSB +: APM_PW_BITS]),
        .pulse_n (sci_pulse_n)
      );

      wire smi_route_enable = chan_irq_enable_reg[APM_IE_SMI_BIT];
      wire hw_smi_enable    = chan_irq_enable_reg[APM_IE_HSMI_BIT];
      wire sci_route_enable = chan_irq_enable_reg[APM_IE_SCI_BIT];
      wire hw_sci_enable    = chan_irq_enable_reg[APM_IE_HSCI_BIT];
      wire firmware_smi_level_bit = chan_irq_control_reg[APM_IC_FW_SMI_BIT];
      wire firmware_sci_level_bit = chan_irq_control_reg[APM_IC_FW_SCI_BIT];

      wire smi_lvl = ~smi_route_enable ? 1'b1 :
                     hw_smi_enable ? smi_pulse_n : firmware_smi_level_bit;
      wire sci_lvl = ~sci_route_enable ? 1'b1 :
                     hw_sci_enable ? sci_pulse_n : firmware_sci_level_bit;

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          host_irq_reg[gi] <= 1'b0;
          smi_n_reg[gi]    <= 1'b1;
          sci_n_reg[gi]    <= 1'b1;
        end else begin
          host_irq_reg[gi] <= irq_lvl;
          smi_n_reg[gi]    <= smi_lvl;
          sci_n_reg[gi]    <= sci_lvl;
        end
      end
    end
  endgenerate

  // Irq control reads back the live channel one IRQ level
  wire [7:0] hiq_read = (host_irq_control_reg & ~(8'h01 << APM_HIQ_FW_IRQ_BIT))
                      | ({7'h00, host_irq_reg[0]} << APM_HIQ_FW_IRQ_BIT);

  wire       any_hit = hit_hic | hit_hiq | (|ch_hit);
  wire [7:0] rd_byte = hit_hic ? host_if_control_reg :
                       hit_hiq ? hiq_read :
                       ch_hit[0] ? ch_rdata[0] :
                       ch_hit[1] ? ch_rdata[1] : 8'h00;

  // Read data captured in the setup phase, held through the access phase
  logic [7:0] prdata_reg;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata_reg <= 8'h00;
    end else if (apb_setup) begin
      prdata_reg <= rd_byte;
    end
  end

  assign prdata  = {24'h000000, prdata_reg};
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~any_hit;

  // Host read port: data address gives output buffer, command gives status
  logic [7:0] host_rdata_reg;
  logic       host_rvalid_reg;

  wire [7:0] host_rd_mux = host_req.sel_data[0] ? ch_dout[0] :
                           host_req.sel_cmd[0]  ? ch_status[0] :
                           host_req.sel_data[1] ? ch_dout[1] :
                           host_req.sel_cmd[1]  ? ch_status[1] : 8'h00;
  wire host_rd_hit = host_req.rd & (|host_req.sel_data | |host_req.sel_cmd);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      host_rdata_reg  <= 8'h00;
      host_rvalid_reg <= 1'b0;
    end else begin
      host_rvalid_reg <= host_rd_hit;
      if (host_rd_hit) begin
        host_rdata_reg <= host_rd_mux;
      end
    end
  end

  assign host_rdata           = host_rdata_reg;
  assign host_rvalid          = host_rvalid_reg;
  assign host_irq             = host_irq_reg;
  assign smi_n                = smi_n_reg;
  assign ec_event_interrupt_n = sci_n_reg;

endmodule : apm_host_channels
`default_nettype wire

/* File: rtl/apm_pkg.sv */
// Package for the two-channel power-management host mailbox.
// Assumes a core-side APB bus and a host port already decoded to chip selects.
package apm_pkg;

  localparam int APM_NUM_CH = 2;

  // Register indices; byte address is four times the index
  localparam logic [15:0] APM_HOST_IF_CTRL_IDX  = 16'hF780;
  localparam logic [15:0] APM_HOST_IRQ_CTRL_IDX = 16'hF782;
  localparam logic [1:0][15:0] APM_ST_IDX    = {16'hF79E, 16'hF78C};
  localparam logic [1:0][15:0] APM_DO_IDX    = {16'hF7A0, 16'hF78E};
  localparam logic [1:0][15:0] APM_DI_IDX    = {16'hF7A2, 16'hF790};
  localparam logic [1:0][15:0] APM_DOC_IDX   = {16'hF7A4, 16'hF792};
  localparam logic [1:0][15:0] APM_DOM_IDX   = {16'hF7A6, 16'hF794};
  localparam logic [1:0][15:0] APM_DIC_IDX   = {16'hF7A8, 16'hF796};
  localparam logic [1:0][15:0] APM_CTL_IDX   = {16'hF7AA, 16'hF798};
  localparam logic [1:0][15:0] APM_IC_IDX    = {16'hF7AC, 16'hF79A};
  localparam logic [1:0][15:0] APM_IE_IDX    = {16'hF7AE, 16'hF79C};

  // Shared host interface control fields
  localparam int APM_HIC_IN_FULL_BIT   = 6;
  localparam int APM_HIC_OUT_EMPTY_BIT = 5;
  localparam int APM_HIC_HW_IRQ_BIT    = 4;
  localparam logic [7:0] APM_HIC_MASK  = 8'h70;
  localparam logic [7:0] APM_HIC_RESET = 8'h00;

  // Shared host IRQ control fields
  localparam int APM_HIQ_INVERT_BIT = 6;
  localparam int APM_HIQ_FW_IRQ_BIT = 2;
  localparam logic [7:0] APM_HIQ_MASK  = 8'h44;
  localparam logic [7:0] APM_HIQ_RESET = 8'h04;

  // Status byte layout
  localparam int APM_ST_OUT_FULL_BIT = 0;
  localparam int APM_ST_IN_FULL_BIT  = 1;
  localparam int APM_ST_CMD_BIT      = 3;
  localparam logic [7:0] APM_ST_CORE_MASK = 8'hF4;
  localparam logic [7:0] APM_ST_RESET     = 8'h00;

  // Channel control fields
  localparam int APM_CTL_MODE_BIT      = 0;
  localparam int APM_CTL_IN_FULL_BIT   = 1;
  localparam int APM_CTL_OUT_EMPTY_BIT = 2;
  localparam int APM_CTL_SCIW_LSB      = 5;
  localparam logic [7:0] APM_CTL_MASK  = 8'hE7;
  localparam logic [7:0] APM_CTL_RESET = 8'h00;

  // Channel interrupt control fields; bits 7:5 read the pending flags
  localparam int APM_IC_SMIW_LSB   = 0;
  localparam int APM_IC_FW_SMI_BIT = 3;
  localparam int APM_IC_FW_SCI_BIT = 4;
  localparam logic [7:0] APM_IC_MASK  = 8'h1F;
  localparam logic [7:0] APM_IC_RESET = 8'h00;

  // Channel interrupt enable fields
  localparam int APM_IE_IRQ_BIT  = 0;
  localparam int APM_IE_SMI_BIT  = 1;
  localparam int APM_IE_HSMI_BIT = 2;
  localparam int APM_IE_SCI_BIT  = 3;
  localparam int APM_IE_HSCI_BIT = 4;
  localparam logic [7:0] APM_IE_MASK  = 8'h1F;
  localparam logic [7:0] APM_IE_RESET = 8'h00;

  localparam int APM_PW_BITS = 3;

  typedef enum logic [1:0] {
    APM_PG_IDLE  = 2'b00,
    APM_PG_PULSE = 2'b01
  } apm_pg_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel_data;
    logic [1:0] sel_cmd;
    logic [7:0] wdata;
  } apm_host_req_t;

endpackage : apm_pkg

/* File: rtl/apm_pulse_gen.sv */
// Active-low pulse of programmable length on a one-cycle trigger.
// Assumes trigger and width come from the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module apm_pulse_gen
  import apm_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   trigger,
  input  wire logic [APM_PW_BITS-1:0] width,
  output logic                        pulse_n
);

  apm_pg_state_t          state_reg;
  apm_pg_state_t          state_next;
  logic [APM_PW_BITS-1:0] cnt_reg;
  logic [APM_PW_BITS-1:0] cnt_next;

  // Width field value N gives N+1 low cycles; a new trigger restarts it
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      APM_PG_IDLE: begin
        if (trigger) begin
          state_next = APM_PG_PULSE;
          cnt_next   = width;
        end
      end
      APM_PG_PULSE: begin
        if (trigger) begin
          cnt_next = width;
        end else if (cnt_reg == '0) begin
          state_next = APM_PG_IDLE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = APM_PG_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= APM_PG_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign pulse_n = (state_reg != APM_PG_PULSE);

endmodule : apm_pulse_gen
`default_nettype wire

/* File: verification/apm_host_model.sv */
// Host processor model driving byte reads and writes at the channel port.
// Assumes the block answers a read with host_rvalid a cycle later.
`timescale 1ns/1ps
`default_nettype none
module apm_host_model
  import apm_pkg::*;
(
  input  wire logic          sys_clk,
  output var  apm_host_req_t host_req,
  input  wire logic [7:0]    host_rdata,
  input  wire logic          host_rvalid
);
  initial host_req = '0;
  // One strobe cycle, then selects drop and data turns over
  task automatic put(input bit rd, input int ch, input bit cmd, input logic [7:0] d);
    @(posedge sys_clk);
    host_req.wr <= !rd;
    host_req.rd <= rd;
    host_req.sel_data <= cmd ? 2'b00 : 2'b01 << ch;
    host_req.sel_cmd <= cmd ? 2'b01 << ch : 2'b00;
    host_req.wdata <= d;
    @(posedge sys_clk);
    host_req <= {6'h00, ~d};
  endtask : put
  task automatic hwrite(input int ch, input bit cmd, input logic [7:0] d);
    put(1'b0, ch, cmd, d);
  endtask : hwrite
  task automatic hread(input int ch, input bit cmd, output logic [7:0] d, output bit ok);
    put(1'b1, ch, cmd, 8'h00);
    ok = 1'b0;
    repeat (4) begin
      @(negedge sys_clk);
      if (!ok && host_rvalid === 1'b1) begin
        d = host_rdata;
        ok = 1'b1;
      end
    end
  endtask : hread
endmodule : apm_host_model
`default_nettype wire

/* File: verification/apm_host_channels_checker.sv */
// Port checker for the power-management mailbox channels.
// Assumes configuration changes only through APB writes on these ports.
`timescale 1ns/1ps
`default_nettype none
module apm_host_channels_checker
  import apm_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          sys_rst,
  input wire logic [17:0]   paddr,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire apm_host_req_t host_req,
  input wire logic [7:0]    host_rdata,
  input wire logic          host_rvalid,
  input wire logic [1:0]    host_irq,
  input wire logic [1:0]    smi_n,
  input wire logic [1:0]    ec_event_interrupt_n,
  input wire logic [1:0]    core_irq_in_full,
  input wire logic [1:0]    core_irq_out_empty
);
  logic [7:0] ie0_reg, ctl0_reg, hic_reg, hiq_reg;
  wire        apw = psel && penable && pwrite;
  wire [15:0] idx = paddr[17:2];
  wire        hw_irq = ctl0_reg[0] | hic_reg[4];
  wire        en_in = ctl0_reg[0] ? ctl0_reg[1] : hic_reg[6];
  wire        en_out = ctl0_reg[0] ? ctl0_reg[2] : hic_reg[5];
  wire        rd0 = host_req.rd && host_req.sel_data[0];
  wire        wr0 = host_req.wr && (host_req.sel_data[0] || host_req.sel_cmd[0]);
  // Shadow of channel one configuration
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ie0_reg <= 8'h00;
      ctl0_reg <= 8'h00;
      hic_reg <= 8'h00;
      hiq_reg <= 8'h04;
    end else if (apw) begin
      if (idx == APM_IE_IDX[0]) ie0_reg <= pwdata[7:0];
      if (idx == APM_CTL_IDX[0]) ctl0_reg <= pwdata[7:0];
      if (idx == APM_HOST_IF_CTRL_IDX) hic_reg <= pwdata[7:0];
      if (idx == APM_HOST_IRQ_CTRL_IDX) hiq_reg <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd0;
    rd0 && !apw;
  endsequence
  chk_rvalid_follows: assert property (host_req.rd && |{host_req.sel_data, host_req.sel_cmd} |=> host_rvalid)
    else $error("host read not answered");
  chk_rvalid_cause: assert property (host_rvalid |-> $past(host_req.rd))
    else $error("host read data without a read");
  chk_in_full_set: assert property (wr0 && en_in && !apw |=> core_irq_in_full[0])
    else $error("input full interrupt missing");
  chk_in_full_gate: assert property (!en_in |-> !core_irq_in_full[0])
    else $error("input full interrupt not gated");
  chk_out_empty_set: assert property (s_rd0 ##0 en_out |=> core_irq_out_empty[0])
    else $error("output empty interrupt missing");
  chk_irq_read_clear: assert property (s_rd0 ##0 hw_irq |=> ##1 host_irq[0] == $past(hiq_reg[6], 2))
    else $error("host irq wrong after data read");
  chk_irq_fw_follow: assert property (!hw_irq && !$past(hw_irq) && !$past(sys_rst) && $stable(hiq_reg[2])
    |-> host_irq[0] == hiq_reg[2])
    else $error("host irq not following firmware bit");
  chk_smi_idle_high: assert property (!ie0_reg[1] && !$past(ie0_reg[1]) |-> smi_n[0])
    else $error("smi active while unrouted");
  chk_event_idle_high: assert property (!ie0_reg[3] && !$past(ie0_reg[3]) |-> ec_event_interrupt_n[0])
    else $error("event active while unrouted");
endmodule : apm_host_channels_checker
bind apm_host_channels apm_host_channels_checker chk_i (.*);
`default_nettype wire

/* File: verification/apm_host_channels_test.sv */
// Self-checking bench for the two power-management mailbox channels.
// Assumes the host model on the host port and APB from the core side.
`timescale 1ns/1ps
`default_nettype none
module apm_host_channels_test
  import apm_pkg::*;
;
  logic          sys_clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic [17:0]   paddr = '0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [31:0]   pwdata = '0;
  wire  [31:0]   prdata;
  wire           pready, pslverr, host_rvalid;
  apm_host_req_t host_req;
  wire  [7:0]    host_rdata;
  wire  [1:0]    host_irq, smi_n, ec_event_interrupt_n, core_irq_in_full, core_irq_out_empty;
  int            fails = 0;
  int            tests_run = 0;
  int            n;
  logic [31:0]   rd;
  logic          err;
  always #25 sys_clk = ~sys_clk;
  apm_host_channels dut (.*);
  apm_host_model host (.*);
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic timeout;
    fails++;
    give_verdict();
  endtask : timeout
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic [15:0] idx, input bit wr, input logic [7:0] wd);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 8);
    if (pready !== 1'b1) timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask : wr
  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rdc
  task automatic hrd(input int ch, input bit cmd, input logic [7:0] exp);
    logic [7:0] d;
    bit         ok;
    host.hread(ch, cmd, d, ok);
    if (!ok) timeout();
    chk(d, exp);
  endtask : hrd
  task automatic settle;
    repeat (2) @(negedge sys_clk);
  endtask : settle
  // Counts low cycles of one channel's SMI or event pin
  task automatic low_cnt(input int ch, input bit ev);
    n = 0;
    repeat (12) begin
      @(negedge sys_clk);
      if ((ev ? ec_event_interrupt_n[ch] : smi_n[ch]) === 1'b0) n++;
    end
  endtask : low_cnt
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rdc(APM_ST_IDX[0], 8'h00);
    rdc(APM_IE_IDX[1], 8'h00);
    rdc(APM_HOST_IRQ_CTRL_IDX, 8'h04);
    apb(16'h0100, 1'b0, 8'h00);
    chk(err, 1'b1);
    wr(APM_HOST_IRQ_CTRL_IDX, 8'h00);
    settle();
    chk(host_irq[0], 1'b0);
    wr(APM_HOST_IF_CTRL_IDX, 8'h40);
    host.hwrite(0, 1'b1, 8'hA5);
    @(negedge sys_clk);
    chk(core_irq_in_full, 2'b01);
    rdc(APM_ST_IDX[0], 8'h0A);
    rdc(APM_DI_IDX[0], 8'hA5);
    rdc(APM_ST_IDX[0], 8'h08);
    host.hwrite(0, 1'b0, 8'h11);
    wr(APM_ST_IDX[0], 8'hFF);
    rdc(APM_ST_IDX[0], 8'hF6);
    rdc(APM_DI_IDX[0], 8'h11);
    wr(APM_HOST_IF_CTRL_IDX, 8'h10);
    wr(APM_IE_IDX[0], 8'h01);
    wr(APM_DO_IDX[0], 8'h3C);
    settle();
    chk(host_irq, 2'b01);
    rdc(APM_HOST_IRQ_CTRL_IDX, 8'h04);
    hrd(0, 1'b1, 8'hF5);
    hrd(0, 1'b0, 8'h3C);
    settle();
    chk(host_irq[0], 1'b0);
    wr(APM_HOST_IRQ_CTRL_IDX, 8'h40);
    settle();
    chk(host_irq[0], 1'b1);
    wr(APM_HOST_IRQ_CTRL_IDX, 8'h00);
    wr(APM_CTL_IDX[0], 8'h05);
    @(negedge sys_clk);
    chk(core_irq_out_empty[0], 1'b1);
    wr(APM_IE_IDX[0], 8'h06);
    wr(APM_IC_IDX[0], 8'h02);
    wr(APM_DO_IDX[0], 8'h01);
    low_cnt(0, 1'b0);
    chk(n, 0);
    hrd(0, 1'b0, 8'h01);
    wr(APM_DOM_IDX[0], 8'h02);
    low_cnt(0, 1'b0);
    chk(n, 3);
    chk(core_irq_out_empty[0], 1'b0);
    rdc(APM_IC_IDX[0], 8'h82);
    hrd(0, 1'b0, 8'h02);
    rdc(APM_IC_IDX[0], 8'h02);
    wr(APM_IE_IDX[0], 8'h02);
    settle();
    chk(smi_n[0], 1'b0);
    wr(APM_CTL_IDX[1], 8'h21);
    wr(APM_IE_IDX[1], 8'h18);
    wr(APM_DOC_IDX[1], 8'h44);
    low_cnt(1, 1'b1);
    chk(n, 2);
    hrd(1, 1'b0, 8'h44);
    host.hwrite(1, 1'b0, 8'h55);
    rdc(APM_DI_IDX[1], 8'h55);
    low_cnt(1, 1'b1);
    chk(n, 0);
    host.hwrite(1, 1'b1, 8'h66);
    rdc(APM_DIC_IDX[1], 8'h66);
    low_cnt(1, 1'b1);
    chk(n, 2);
    rdc(APM_IC_IDX[1], 8'h20);
    host.hwrite(1, 1'b0, 8'h77);
    rdc(APM_IC_IDX[1], 8'h00);
    wr(APM_IE_IDX[1], 8'h08);
    settle();
    chk(ec_event_interrupt_n[1], 1'b0);
    wr(APM_IC_IDX[1], 8'h10);
    settle();
    chk(ec_event_interrupt_n[1], 1'b1);
    wr(APM_CTL_IDX[1], 8'h02);
    @(negedge sys_clk);
    chk(core_irq_in_full, 2'b10);
    give_verdict();
  end
endmodule : apm_host_channels_test
`default_nettype wire
